// File: rtl/res_cfg.svh
/*
   Named constants for the receiver status and event strobe block: register offsets,
   field positions, reset values and timing figures.
   Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef RES_CFG_SVH
`define RES_CFG_SVH

// timing
`define RES_CLK_PERIOD_NS 50
`define RES_MARK_MIN_NS 150
`define RES_MARK_QUAL_CYC ((`RES_MARK_MIN_NS + `RES_CLK_PERIOD_NS - 1) / `RES_CLK_PERIOD_NS)
`define RES_REBOOT_NS 100000
`define RES_REBOOT_CYC (`RES_REBOOT_NS / `RES_CLK_PERIOD_NS)
`define RES_MARK_CNT_W 8
`define RES_HALF_W 24

// register offsets (byte addresses)
`define RES_OFS_CTRL 8'h00
`define RES_OFS_STATUS 8'h04
`define RES_OFS_MARK_POL 8'h08
`define RES_OFS_OUT_POL 8'h0C
`define RES_OFS_IRQ_STATUS 8'h20
`define RES_OFS_IRQ_MASK 8'h24
`define RES_PAGE_HALF 4'h1
`define RES_PAGE_MARK_TIME 4'h3

// address fields
`define RES_ADDR_PAGE 7:4
`define RES_ADDR_WORD 3:2
`define RES_ADDR_BYTE 1:0
`define RES_ADDR_ALIGNED 2'h0

// status and per-channel fields
`define RES_STATUS_FIELD 5:0
`define RES_CH_FIELD 3:0

// control register fields
`define RES_CTRL_BOOT_DONE 0
`define RES_CTRL_FATAL 1
`define RES_CTRL_ERROR 2
`define RES_CTRL_SOLUTION 3

// interrupt status fields: bits 3..0 marks, bit 4 error entry
`define RES_IRQ_ERR 4
`define RES_IRQ_W 5

// reset values: polarity 0 = active low
`define RES_MARK_POL_RST 4'h0
`define RES_OUT_POL_RST 4'h0
`define RES_HALF_RST 24'h000000

`endif

// File: rtl/res_pkg.sv
/*
   Types shared by the receiver status and event strobe design.
   Assumes res_cfg.svh supplies the widths.
*/
`include "res_cfg.svh"

package res_pkg;

   typedef enum logic [2:0]
   {
      RES_BOOT = 3'h1,
      RES_RUN = 3'h2,
      RES_REBOOT = 3'h4
   } res_sys_state_type;

   typedef struct packed
   {
      logic error;
      logic ready;
      logic pos_valid;
   } res_strobes_type;

   typedef struct packed
   {
      logic sync1;
      logic sync2;
      logic [`RES_MARK_CNT_W-1:0] cnt;
      logic fired;
      logic event_out;
   } res_mark_state_type;

   typedef struct packed
   {
      logic [`RES_HALF_W-1:0] cnt;
      logic level;
      logic pin;
   } res_pulse_state_type;

   typedef struct packed
   {
      res_sys_state_type state;
      logic [31:0] reboot_cnt;
      logic err_lvl;
      logic sol_lvl;
      logic [3:0] mark_pol;
      logic [3:0] out_pol;
      logic [3:0][`RES_HALF_W-1:0] half;
      logic [`RES_IRQ_W-1:0] irq_st;
      logic [`RES_IRQ_W-1:0] irq_mask;
      logic [31:0] stamp;
      logic [3:0][31:0] mark_time;
      res_strobes_type strobes;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } res_top_state_type;

endpackage : res_pkg

// File: rtl/res_mark_in.sv
/*
   One event mark input: two-flop synchroniser, polarity select, qualified leading edge.
   Assumes an asynchronous pin and a single system clock.
*/
`timescale 1ns/1ps
`include "res_cfg.svh"

module res_mark_in #(
   parameter int QUAL_CYCLES = `RES_MARK_QUAL_CYC
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_pin,
   input wire logic i_active_high,
   output logic o_event
);

   res_pkg::res_mark_state_type r_reg;
   res_pkg::res_mark_state_type r_next;
   logic active;

   always_comb
   begin
      r_next = r_reg;
      r_next.sync1 = i_pin;
      r_next.sync2 = r_reg.sync1;
      r_next.event_out = 1'b0;
      active = i_active_high ? r_reg.sync2 : ~r_reg.sync2;
      if (!active)
      begin
         r_next.cnt = '0;
         r_next.fired = 1'b0;
      end
      else if (!r_reg.fired)
      begin
         // counts cycles in the active level; a shorter glitch never reaches the limit
         if (r_reg.cnt >= `RES_MARK_CNT_W'(QUAL_CYCLES - 1))
         begin
            r_next.event_out = 1'b1;
            r_next.fired = 1'b1;
         end
         else
         begin
            r_next.cnt = r_reg.cnt + `RES_MARK_CNT_W'(1);
         end
      end
   end

   // fired starts set so a level already active at reset is not taken as an edge
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         r_reg <= '{sync1: 1'b0, sync2: 1'b0, cnt: '0, fired: 1'b1, event_out: 1'b0};
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign o_event = r_reg.event_out;

endmodule : res_mark_in

// File: rtl/res_pulse_out.sv
/*
   One programmable-frequency event output: toggles every half period, polarity select.
   Assumes a single system clock; highest rate is half the clock rate.
*/
`timescale 1ns/1ps
`include "res_cfg.svh"

module res_pulse_out (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic [`RES_HALF_W-1:0] i_half,
   input wire logic i_active_high,
   output logic o_pin
);

   res_pkg::res_pulse_state_type r_reg;
   res_pkg::res_pulse_state_type r_next;

   always_comb
   begin
      r_next = r_reg;
      if (i_half == `RES_HALF_RST)
      begin
         // zero half period means 0 Hz: output rests inactive
         r_next.cnt = '0;
         r_next.level = 1'b0;
      end
      else if (r_reg.cnt >= i_half - `RES_HALF_W'(1))
      begin
         r_next.cnt = '0;
         r_next.level = ~r_reg.level;
      end
      else
      begin
         r_next.cnt = r_reg.cnt + `RES_HALF_W'(1);
      end
      r_next.pin = i_active_high ? r_next.level : ~r_next.level;
   end

   // pin resets high: inactive for the default active-low sense
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         r_reg <= '{cnt: '0, level: 1'b0, pin: 1'b1};
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign o_pin = r_reg.pin;

endmodule : res_pulse_out

// File: rtl/res_top.sv
/*
   Receiver status and event strobe block: error, command-ready and position-valid
   strobes, four event mark inputs with time logs, four timed pulse outputs, APB slave.
   Assumes one 20 MHz clock, asynchronous active-low reset and firmware driving CTRL.
*/
// How it works
// - the error strobe is low normally and high while the receiver is in an error state.
// - each mark input fires on its leading edge after at least 150 ns and logs time.
// - mark inputs sense active low after reset, polarity set per input by software.
// - pulse outputs are active low after reset, with a programmable half period.
// - the command-ready strobe is high while the receiver accepts commands.
// - command-ready stays low through boot and through any reset.
// - a recoverable error raises the error strobe while command-ready stays high.
// - when the error strobe rises the position-valid strobe is forced low.
// - a fatal error reboots with all three strobes low until restart completes.
// - position-valid is high only while a valid solution is available.
`timescale 1ns/1ps
`include "res_cfg.svh"

module res_top #(
   parameter int REBOOT_CYCLES = `RES_REBOOT_CYC,
   parameter int QUAL_CYCLES = `RES_MARK_QUAL_CYC
) (
   input wire logic I_CLOCK,
   input wire logic I_ARST_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   output logic [31:0] O_PRDATA,
   input wire logic [3:0] I_EVENT_MARK_INPUT,
   output logic [3:0] O_TIMED_PULSE_OUTPUT,
   output logic O_ERROR,
   output logic O_COMMAND_READY_FLAG,
   output logic O_POS_VALID,
   output logic O_IRQ
);

   res_pkg::res_top_state_type r_reg;
   res_pkg::res_top_state_type r_next;
   logic [3:0] mark_event;
   logic access;
   logic commit;
   logic wr;
   logic boot_done;
   logic fatal;
   logic err_rise;
   logic [`RES_IRQ_W-1:0] hw_set;
   logic running;
   logic [1:0] word_idx;
   logic sel_ctrl;
   logic sel_status;
   logic sel_mark_pol;
   logic sel_out_pol;
   logic sel_irq_st;
   logic sel_irq_mask;
   logic sel_half;
   logic sel_mark_time;

   // one decode feeds both the read and the write path,
   // so the two address maps cannot drift apart
   assign word_idx = I_PADDR[`RES_ADDR_WORD];
   assign sel_ctrl = (I_PADDR == `RES_OFS_CTRL);
   assign sel_status = (I_PADDR == `RES_OFS_STATUS);
   assign sel_mark_pol = (I_PADDR == `RES_OFS_MARK_POL);
   assign sel_out_pol = (I_PADDR == `RES_OFS_OUT_POL);
   assign sel_irq_st = (I_PADDR == `RES_OFS_IRQ_STATUS);
   assign sel_irq_mask = (I_PADDR == `RES_OFS_IRQ_MASK);
   assign sel_half = (I_PADDR[`RES_ADDR_PAGE] == `RES_PAGE_HALF)
      && (I_PADDR[`RES_ADDR_BYTE] == `RES_ADDR_ALIGNED);
   assign sel_mark_time = (I_PADDR[`RES_ADDR_PAGE] == `RES_PAGE_MARK_TIME)
      && (I_PADDR[`RES_ADDR_BYTE] == `RES_ADDR_ALIGNED);

   // four independent channels; nothing is shared between them
   for (genvar g = 0; g < 4; g++)
   begin : g_ch
      res_mark_in #(
         .QUAL_CYCLES(QUAL_CYCLES)
      ) u_mark (
         .i_clk(I_CLOCK),
         .i_arst_n(I_ARST_N),
         .i_pin(I_EVENT_MARK_INPUT[g]),
         .i_active_high(r_reg.mark_pol[g]),
         .o_event(mark_event[g])
      );
      res_pulse_out u_pulse (
         .i_clk(I_CLOCK),
         .i_arst_n(I_ARST_N),
         .i_half(r_reg.half[g]),
         .i_active_high(r_reg.out_pol[g]),
         .o_pin(O_TIMED_PULSE_OUTPUT[g])
      );
   end

   always_comb
   begin
      r_next = r_reg;
      r_next.pready = 1'b0;
      r_next.pslverr = 1'b0;
      // free-running stamp wraps silently; software must allow for the wrap
      r_next.stamp = r_reg.stamp + 32'h00000001;
      // two-cycle access: pready is registered, the write lands on the pready edge
      access = I_PSEL & I_PENABLE & ~r_reg.pready;
      commit = I_PSEL & I_PENABLE & r_reg.pready;
      wr = commit & I_PWRITE;
      boot_done = 1'b0;
      fatal = 1'b0;
      err_rise = 1'b0;
      hw_set = '0;
      running = 1'b0;

      if (access)
      begin
         r_next.pready = 1'b1;
         r_next.prdata = 32'h00000000;
         if (sel_ctrl)
         begin
            r_next.prdata[`RES_CTRL_ERROR] = r_reg.err_lvl;
            r_next.prdata[`RES_CTRL_SOLUTION] = r_reg.sol_lvl;
         end
         else if (sel_status)
         begin
            r_next.prdata[`RES_STATUS_FIELD] = {r_reg.state, r_reg.strobes};
         end
         else if (sel_mark_pol)
         begin
            r_next.prdata[`RES_CH_FIELD] = r_reg.mark_pol;
         end
         else if (sel_out_pol)
         begin
            r_next.prdata[`RES_CH_FIELD] = r_reg.out_pol;
         end
         else if (sel_irq_st)
         begin
            r_next.prdata[`RES_IRQ_W-1:0] = r_reg.irq_st;
         end
         else if (sel_irq_mask)
         begin
            r_next.prdata[`RES_IRQ_W-1:0] = r_reg.irq_mask;
         end
         else if (sel_half)
         begin
            r_next.prdata[`RES_HALF_W-1:0] = r_reg.half[word_idx];
         end
         else if (sel_mark_time)
         begin
            r_next.prdata = r_reg.mark_time[word_idx];
         end
         else
         begin
            // unmapped or misaligned: error answer, nothing changes
            r_next.pslverr = 1'b1;
         end
      end
      else if (commit)
      begin
         // the master takes the word at this edge; no stale word is left on the bus
         r_next.prdata = 32'h00000000;
      end

      // a write lands only on the completing edge, never after an error answer
      if (wr && !r_reg.pslverr)
      begin
         if (sel_ctrl)
         begin
            // boot_done and fatal are pulses: they act on this edge only
            boot_done = I_PWDATA[`RES_CTRL_BOOT_DONE];
            fatal = I_PWDATA[`RES_CTRL_FATAL];
            err_rise = I_PWDATA[`RES_CTRL_ERROR] & ~r_reg.err_lvl;
            r_next.err_lvl = I_PWDATA[`RES_CTRL_ERROR];
            r_next.sol_lvl = I_PWDATA[`RES_CTRL_SOLUTION];
         end
         else if (sel_mark_pol)
         begin
            r_next.mark_pol = I_PWDATA[`RES_CH_FIELD];
         end
         else if (sel_out_pol)
         begin
            r_next.out_pol = I_PWDATA[`RES_CH_FIELD];
         end
         else if (sel_irq_st)
         begin
            r_next.irq_st = r_reg.irq_st & ~I_PWDATA[`RES_IRQ_W-1:0];
         end
         else if (sel_irq_mask)
         begin
            r_next.irq_mask = I_PWDATA[`RES_IRQ_W-1:0];
         end
         else if (sel_half)
         begin
            r_next.half[word_idx] = I_PWDATA[`RES_HALF_W-1:0];
         end
      end

      // entering an error drops the solution; firmware must re-assert it afterwards
      if (err_rise)
      begin
         r_next.sol_lvl = 1'b0;
         hw_set[`RES_IRQ_ERR] = 1'b1;
      end

      for (int i = 0; i < 4; i++)
      begin
         if (mark_event[i])
         begin
            r_next.mark_time[i] = r_reg.stamp;
            hw_set[i] = 1'b1;
         end
      end
      // a hardware event in the clearing cycle survives the clear
      r_next.irq_st = r_next.irq_st | hw_set;

      // boot and reboot override firmware's levels so a stale error cannot show through
      case (r_reg.state)
         res_pkg::RES_BOOT:
         begin
            r_next.err_lvl = 1'b0;
            r_next.sol_lvl = 1'b0;
            if (boot_done)
            begin
               r_next.state = res_pkg::RES_RUN;
            end
         end
         res_pkg::RES_RUN:
         begin
            if (fatal)
            begin
               r_next.state = res_pkg::RES_REBOOT;
               r_next.reboot_cnt = 32'h00000000;
               r_next.err_lvl = 1'b0;
               r_next.sol_lvl = 1'b0;
            end
         end
         res_pkg::RES_REBOOT:
         begin
            // the counter runs only here, so its width only bounds REBOOT_CYCLES
            r_next.err_lvl = 1'b0;
            r_next.sol_lvl = 1'b0;
            r_next.reboot_cnt = r_reg.reboot_cnt + 32'h00000001;
            if (r_reg.reboot_cnt >= 32'(REBOOT_CYCLES - 1))
            begin
               r_next.state = res_pkg::RES_BOOT;
            end
         end
         default:
         begin
            r_next.state = res_pkg::RES_BOOT;
         end
      endcase

      running = (r_next.state == res_pkg::RES_RUN);
      // ready stays up through recoverable errors; only boot and reboot drop it
      r_next.strobes.ready = running;
      r_next.strobes.error = running & r_next.err_lvl;
      r_next.strobes.pos_valid = running & r_next.sol_lvl
         & ~r_next.err_lvl;
      r_next.irq = |(r_next.irq_st & r_next.irq_mask);
   end

   // all state resets at once; strobes come out low so command-ready is down at release
   always_ff @(posedge I_CLOCK or negedge I_ARST_N)
   begin
      if (!I_ARST_N)
      begin
         r_reg <= '{
            state: res_pkg::RES_BOOT,
            reboot_cnt: 32'h00000000,
            err_lvl: 1'b0,
            sol_lvl: 1'b0,
            mark_pol: `RES_MARK_POL_RST,
            out_pol: `RES_OUT_POL_RST,
            half: '0,
            irq_st: '0,
            irq_mask: '0,
            stamp: 32'h00000000,
            mark_time: '0,
            strobes: '0,
            irq: 1'b0,
            pready: 1'b0,
            pslverr: 1'b0,
            prdata: 32'h00000000
         };
      end
      else
      begin
         r_reg <= r_next;
      end
   end

   assign O_PREADY = r_reg.pready;
   assign O_PSLVERR = r_reg.pslverr;
   assign O_PRDATA = r_reg.prdata;
   assign O_ERROR = r_reg.strobes.error;
   assign O_COMMAND_READY_FLAG = r_reg.strobes.ready;
   assign O_POS_VALID = r_reg.strobes.pos_valid;
   assign O_IRQ = r_reg.irq;

endmodule : res_top

// File: tb/res_top_asserts.sv
/*
   checker for res_top: strobe sequencing and bus answer relations at the top ports.
   assumes the bind below and REBOOT_CYCLES of at least 8.
*/
`timescale 1ns/1ps
module res_top_asserts #(
   parameter int REBOOT_CYCLES = 8
) (
   input wire logic I_CLOCK,
   input wire logic I_ARST_N,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic O_PREADY,
   input wire logic [3:0] O_TIMED_PULSE_OUTPUT,
   input wire logic O_ERROR,
   input wire logic O_COMMAND_READY_FLAG,
   input wire logic O_POS_VALID
);
   logic ctl_wr;
   logic boot_wr;
   logic err_wr;
   logic sol_wr;
   assign ctl_wr = O_PREADY && I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == 8'h00;
   assign boot_wr = ctl_wr && I_PWDATA[0];
   assign err_wr = ctl_wr && I_PWDATA[2];
   assign sol_wr = ctl_wr && I_PWDATA[3] && !I_PWDATA[2];
   default clocking cb @(posedge I_CLOCK);
   endclocking
   default disable iff (!I_ARST_N);
   sequence s_fatal;
      ctl_wr && I_PWDATA[1] && O_COMMAND_READY_FLAG;
   endsequence
   sequence s_quiet;
      !O_COMMAND_READY_FLAG && !O_ERROR && !O_POS_VALID;
   endsequence
   a_fatal_quiet: assert property (s_fatal |=> s_quiet [*8])
      else $error("strobes not quiet during reboot");
   a_boot_idle: assert property (!$past(I_ARST_N) |-> !O_COMMAND_READY_FLAG)
      else $error("command ready high right after reset");
   a_pulse_idle: assert property (!$past(I_ARST_N) |-> O_TIMED_PULSE_OUTPUT == 4'hF)
      else $error("pulse outputs not idle high after reset");
   a_ready_cause: assert property ($rose(O_COMMAND_READY_FLAG) |-> $past(boot_wr))
      else $error("command ready rose without boot done");
   a_err_cause: assert property ($rose(O_ERROR) |-> $past(err_wr))
      else $error("error strobe rose without error state");
   a_pos_cause: assert property ($rose(O_POS_VALID) |-> $past(sol_wr))
      else $error("position valid rose without solution");
   a_err_in_run: assert property (O_ERROR |-> O_COMMAND_READY_FLAG)
      else $error("error strobe without command ready");
   a_err_kills_pos: assert property (O_ERROR |-> !O_POS_VALID)
      else $error("position valid high with error");
   a_slave_answer: assert property (I_PSEL && I_PENABLE && !O_PREADY |=> O_PREADY)
      else $error("bus access not answered after one wait state");
endmodule : res_top_asserts

bind res_top res_top_asserts #(
   .REBOOT_CYCLES(REBOOT_CYCLES)
) res_top_asserts_i (
   .I_CLOCK(I_CLOCK),
   .I_ARST_N(I_ARST_N),
   .I_PSEL(I_PSEL),
   .I_PENABLE(I_PENABLE),
   .I_PWRITE(I_PWRITE),
   .I_PADDR(I_PADDR),
   .I_PWDATA(I_PWDATA),
   .O_PREADY(O_PREADY),
   .O_TIMED_PULSE_OUTPUT(O_TIMED_PULSE_OUTPUT),
   .O_ERROR(O_ERROR),
   .O_COMMAND_READY_FLAG(O_COMMAND_READY_FLAG),
   .O_POS_VALID(O_POS_VALID)
);

// File: tb/res_host_model.sv
/*
   host side model: drives the four mark pins, idle at the inactive level.
   assumes the bench calls its tasks from the main sequence.
*/
`timescale 1ns/1ps
module res_host_model (
   input wire logic i_clk,
   output logic [3:0] o_mark
);
   logic [3:0] act_hi;
   initial
   begin
      act_hi = 4'h0;
      o_mark = 4'hF;
   end
   // idle is the inverse of the active level, so a polarity change re-idles the pins
   task automatic set_pol(input logic [3:0] pol);
      @(posedge i_clk);
      act_hi = pol;
      o_mark <= ~pol;
   endtask : set_pol
   // a short mark is only sent when the bench asks for a refusal
   task automatic mark(input int idx, input int cyc);
      @(posedge i_clk);
      o_mark[idx] <= act_hi[idx];
      repeat (cyc) @(posedge i_clk);
      o_mark[idx] <= ~act_hi[idx];
   endtask : mark
endmodule : res_host_model

// File: tb/res_top_tb.sv
/*
   bench for res_top: bus tasks, host model on the mark pins, strobe and register checks.
   assumes REBOOT_CYCLES cut to 8 and a 20 MHz clock.
*/
`timescale 1ns/1ps
module res_top_tb;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic psel = 1'b0;
   logic pen = 1'b0;
   logic pwr = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic pready;
   logic pslverr;
   logic [31:0] prdata;
   logic [3:0] mark;
   logic [3:0] pout;
   logic err;
   logic rdy;
   logic pos;
   logic irq;
   logic [31:0] rd;
   logic slv;
   int fail_count = 0;
   int num_checks = 0;
   int n;
   int k;
   int cyc = 0;
   int t0;
   logic [31:0] tm;
   always #25 clk = ~clk;
   // bench cycle count, used to predict the spacing of two mark time logs
   always @(posedge clk) cyc <= cyc + 1;
   res_top #(
      .REBOOT_CYCLES(8)
   ) res_top_i (
      .I_CLOCK(clk),
      .I_ARST_N(arst_n),
      .I_PSEL(psel),
      .I_PENABLE(pen),
      .I_PWRITE(pwr),
      .I_PADDR(paddr),
      .I_PWDATA(pwdata),
      .O_PREADY(pready),
      .O_PSLVERR(pslverr),
      .O_PRDATA(prdata),
      .I_EVENT_MARK_INPUT(mark),
      .O_TIMED_PULSE_OUTPUT(pout),
      .O_ERROR(err),
      .O_COMMAND_READY_FLAG(rdy),
      .O_POS_VALID(pos),
      .O_IRQ(irq)
   );
   res_host_model res_host_model_i (
      .i_clk(clk),
      .o_mark(mark)
   );
   task automatic end_sim;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
      begin
         $display("Regression OK");
      end
      else
      begin
         $display("Regression broken");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         fail_count++;
         $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int c;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      c = 0;
      do
      begin
         @(posedge clk);
         c++;
      end
      while (pready !== 1'b1 && c < 20);
      if (c == 20)
      begin
         fail_count++;
         end_sim();
      end
      rd = prdata;
      slv = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rchk
   // strobes land on the write edge itself; sck samples them one cycle later
   task automatic sck(input logic [2:0] e);
      @(posedge clk);
      chk({29'h0, err, rdy, pos}, {29'h0, e});
   endtask : sck
   task automatic wchg(input int i);
      logic v;
      v = pout[i];
      k = 0;
      while (pout[i] === v && k < 50)
      begin
         @(posedge clk);
         k++;
      end
      if (k == 50)
      begin
         fail_count++;
         end_sim();
      end
   endtask : wchg
   initial
   begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      sck(3'b000);
      chk({28'h0, pout}, 32'hF);
      rchk(8'h04, 32'h08);
      rchk(8'h08, 32'h0);
      rchk(8'h0C, 32'h0);
      apb(1'b1, 8'h00, 32'h8);
      apb(1'b1, 8'h00, 32'h1);
      sck(3'b010);
      rchk(8'h04, 32'h12);
      apb(1'b1, 8'h00, 32'h8);
      sck(3'b011);
      apb(1'b1, 8'h00, 32'hC);
      sck(3'b110);
      rchk(8'h20, 32'h10);
      apb(1'b1, 8'h24, 32'h10);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      apb(1'b1, 8'h20, 32'h10);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      apb(1'b1, 8'h00, 32'h0);
      sck(3'b010);
      for (n = 0; n < 4; n++)
      begin
         res_host_model_i.mark(n, 2);
         repeat (10) @(posedge clk);
         rchk(8'h20, 32'h0);
         res_host_model_i.mark(n, 4);
         repeat (10) @(posedge clk);
         rchk(8'h20, 32'h1 << n);
         apb(1'b1, 8'h20, 32'hF);
      end
      // flipping polarity with the pin idle may log a stray mark, so clear after
      apb(1'b1, 8'h08, 32'h1);
      res_host_model_i.set_pol(4'h1);
      repeat (10) @(posedge clk);
      apb(1'b1, 8'h20, 32'hF);
      res_host_model_i.mark(0, 4);
      t0 = cyc;
      repeat (10) @(posedge clk);
      rchk(8'h20, 32'h1);
      // a second mark on the same input: its time log lies exactly the pin spacing later
      apb(1'b0, 8'h30, 32'h0);
      tm = rd;
      res_host_model_i.mark(0, 4);
      t0 = cyc - t0;
      repeat (10) @(posedge clk);
      rchk(8'h30, tm + 32'(t0));
      for (n = 0; n < 4; n++)
      begin
         apb(1'b1, 8'h10 + 8'(4 * n), 32'(n + 1));
         wchg(n);
         wchg(n);
         chk(32'(k), 32'(n + 1));
      end
      apb(1'b1, 8'h10, 32'h0);
      apb(1'b1, 8'h14, 32'h0);
      apb(1'b1, 8'h0C, 32'h2);
      repeat (4) @(posedge clk);
      chk({30'h0, pout[1:0]}, 32'h1);
      apb(1'b0, 8'h40, 32'h0);
      chk({31'h0, slv}, 32'h1);
      apb(1'b1, 8'h00, 32'h8);
      apb(1'b1, 8'h00, 32'h2);
      sck(3'b000);
      repeat (12) @(posedge clk);
      rchk(8'h04, 32'h08);
      apb(1'b1, 8'h00, 32'h1);
      sck(3'b010);
      arst_n <= 1'b0;
      sck(3'b000);
      end_sim();
   end
endmodule : res_top_tb
